// ===== mimc_cfg.svh
// Offsets, field positions, reset values and constants of the mode control bank
`ifndef MIMC_CFG_SVH
`define MIMC_CFG_SVH
`define MIMC_ADDR_W            16
`define MIMC_MODE_OFS          16'h209C
`define MIMC_SCRATCH_OFS       16'h21D0
`define MIMC_RDRET_OFS         16'h20FC
`define MIMC_MODE_RST          16'h0000
`define MIMC_SCRATCH_RST       16'h0307
`define MIMC_RDRET_RST         16'h0000
`define MIMC_MODE_WMASK        16'hEDEF
`define MIMC_SCRATCH_WMASK     16'h7FFF
`define MIMC_RDRET_WMASK       16'h817F
`define MIMC_MASK_LSB          16
`define MIMC_MODE_SUSPEND      15
`define MIMC_MODE_ASYNC_FLIP   14
`define MIMC_MODE_FLUSH_PERF   13
`define MIMC_MODE_INV_UPD      11
`define MIMC_MODE_POW2_FENCE   10
`define MIMC_MODE_RINGS_IDLE   9
`define MIMC_MODE_STOP_RINGS   8
`define MIMC_MODE_VS_LRA       7
`define MIMC_MODE_VS_TIMER     6
`define MIMC_MODE_FBC_MOD      5
`define MIMC_MODE_BIG_BATCH    3
`define MIMC_MODE_PC_DEPTH     2
`define MIMC_MODE_DUMMY_DIS    1
`define MIMC_MODE_IDMASK_DIS   0
`define MIMC_SCR_DUAL_DIS      14
`define MIMC_SCR_CLIP_SW       12
`define MIMC_SCR_BAD_VTX       9
`define MIMC_RDRET_LOOPBACK    15
`define MIMC_RDRET_CURSOR      3
`define MIMC_RDRET_SPRITE_A    2
`define MIMC_NUM_CLIENTS       5
`define MIMC_DATA_W            32
`define MIMC_PTR_W             32
`define MIMC_LFSR_SEED         32'hACE1_2468
`define MIMC_LFSR_TAPS         32'h8020_0003
`define MIMC_VS_BATCH          2'h2
`define MIMC_PC_DEPTH_DEEP     4'h8
`define MIMC_PC_DEPTH_SHALLOW  4'h4
`endif

// ===== mimc_monitor.sv
// Port assertions for the mode control bank
`timescale 1ns/10ps
`include "mimc_cfg.svh"
module mimc_monitor (
    input wire logic        clk_i,
    input wire logic        arst_n_i,
    input wire logic        reg_wr_i,
    input wire logic        reg_rd_i,
    input wire logic [15:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic [31:0] reg_rdata_o,
    input wire logic        reg_rvld_o,
    input wire logic        parser_idle_i,
    input wire logic        arb_idle_i,
    input wire logic        rings_stop_o,
    input wire logic        flush_req_i,
    input wire logic        flush_done_i,
    input wire logic        flush_go_o,
    input wire logic        flush_held_o,
    input wire logic        dummy_rd_o,
    input wire logic        int_ack_pend_i,
    input wire logic        id_int_mask_o
);
    logic mwr;
    logic mrd;
    logic idl;
    // Mode register decodes and the combined parser and arbiter idle
    assign mwr = reg_wr_i && (reg_addr_i == `MIMC_MODE_OFS);
    assign mrd = reg_rd_i && (reg_addr_i == `MIMC_MODE_OFS);
    assign idl = parser_idle_i && arb_idle_i;
    default clocking dc @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);
    property p_ans; reg_rd_i |=> reg_rvld_o; endproperty
    a_ans: assert property (p_ans) else $error("read unanswered");
    property p_hi; reg_rvld_o |-> reg_rdata_o[31:16] == 16'h0000; endproperty
    a_hi: assert property (p_hi) else $error("mask half not zero");
    property p_stop; mwr && reg_wdata_i[24] |=> ##1 rings_stop_o == $past(reg_wdata_i[8], 2); endproperty
    a_stop: assert property (p_stop) else $error("stop not written");
    property p_keep; mwr && !reg_wdata_i[24] |=> ##1 rings_stop_o == $past(rings_stop_o); endproperty
    a_keep: assert property (p_keep) else $error("unmasked bit changed");
    property p_idle; mrd && $past(arst_n_i) |=> reg_rdata_o[9] == $past(idl, 2); endproperty
    a_idle: assert property (p_idle) else $error("idle bit wrong");
    property p_go; flush_go_o |-> $past(flush_req_i); endproperty
    a_go: assert property (p_go) else $error("flush without request");
    property p_req; flush_req_i |=> flush_go_o || flush_held_o; endproperty
    a_req: assert property (p_req) else $error("flush lost");
    property p_held; flush_held_o |=> flush_held_o; endproperty
    a_held: assert property (p_held) else $error("held flag dropped");
    property p_dummy; dummy_rd_o |-> $past(flush_done_i); endproperty
    a_dummy: assert property (p_dummy) else $error("stray dummy read");
    property p_mask; id_int_mask_o |-> $past(int_ack_pend_i); endproperty
    a_mask: assert property (p_mask) else $error("stray mask");
    c_idle: cover property (reg_rvld_o && reg_rdata_o[9] && rings_stop_o);
    c_held: cover property (flush_held_o && flush_req_i);
    c_go: cover property (flush_go_o);
endmodule

bind mimc_top mimc_monitor mon_u (.clk_i(clk_i), .arst_n_i(arst_n_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_rdata_o(reg_rdata_o), .reg_rvld_o(reg_rvld_o), .parser_idle_i(parser_idle_i),
    .arb_idle_i(arb_idle_i), .rings_stop_o(rings_stop_o), .flush_req_i(flush_req_i),
    .flush_done_i(flush_done_i), .flush_go_o(flush_go_o), .flush_held_o(flush_held_o),
    .dummy_rd_o(dummy_rd_o), .int_ack_pend_i(int_ack_pend_i), .id_int_mask_o(id_int_mask_o));

// ===== mimc_pkg.sv
// Types shared by the mode control bank
package mimc_pkg;
    // Read data for one display or fetch client
    typedef struct packed {
        logic        vld;
        logic [31:0] data;
    } mimc_rdata_s;

    // Steering outputs decoded from the mode and scratch registers
    typedef struct packed {
        logic       stall_in_streamer;
        logic       slow_restore;
        logic       pow2_fences;
        logic       vs_lra;
        logic       vs_timer_en;
        logic [1:0] vs_batch;
        logic       fbc_watch;
        logic [3:0] pc_depth;
        logic       dual_dispatch_off;
        logic [1:0] clip_mode;
        logic       bad_vtx_must_clip;
    } mimc_ctrl_s;
endpackage

// ===== mimc_top.sv
// Mode, scratch and read-return select registers with their steering logic
`timescale 1ns/10ps
`include "mimc_cfg.svh"

module mimc_top (
    input  wire logic                        clk_i,
    input  wire logic                        arst_n_i,
    // Memory-mapped register port
    input  wire logic                        reg_wr_i,
    input  wire logic                        reg_rd_i,
    input  wire logic [`MIMC_ADDR_W-1:0]     reg_addr_i,
    input  wire logic [31:0]                 reg_wdata_i,
    output logic      [31:0]                 reg_rdata_o,
    output logic                             reg_rvld_o,
    // Client read returns: 0 plane A, 1 plane B, 2 plane C, 3 cursor, 4 sprite A
    input  mimc_pkg::mimc_rdata_s [`MIMC_NUM_CLIENTS-1:0] mem_rdata_i,
    output mimc_pkg::mimc_rdata_s [`MIMC_NUM_CLIENTS-1:0] cli_rdata_o,
    // Command parser and ring status
    input  wire logic                        parser_idle_i,
    input  wire logic                        arb_idle_i,
    output logic                             rings_stop_o,
    // Ring head update pointer
    input  wire logic [`MIMC_PTR_W-1:0]      head_ptr_i,
    input  wire logic [`MIMC_PTR_W-1:0]      upd_ptr_i,
    input  wire logic                        upd_ptr_vld_i,
    output logic                             upd_ptr_clr_o,
    // Flush handling
    input  wire logic                        flush_req_i,
    input  wire logic                        flush_done_i,
    output logic                             flush_go_o,
    output logic                             flush_held_o,
    output logic                             dummy_rd_o,
    // Interrupt masking and batch check
    input  wire logic                        int_ack_pend_i,
    output logic                             id_int_mask_o,
    input  wire logic                        batch_big_i,
    output logic                             batch_refuse_o,
    // Decoded steering
    output mimc_pkg::mimc_ctrl_s             ctrl_o
);

    logic [15:0]             mode_r;
    logic [15:0]             scratch_r;
    logic [15:0]             rdret_r;
    logic [31:0]             lfsr_r;
    logic [31:0]             lfsr_nxt;
    logic                    idle_r;
    logic                    mode_wr;
    logic                    scratch_wr;
    logic                    rdret_wr;
    // Steering flops behind ctrl_o
    logic                    flip_stall_r;
    logic                    slow_restore_r;
    logic                    pow2_r;
    logic                    vs_lra_r;
    logic                    vs_timer_r;
    logic [1:0]              vs_batch_r;
    logic                    fbc_watch_r;
    logic [3:0]              pc_depth_r;
    logic                    dual_off_r;
    logic [1:0]              clip_mode_r;
    logic                    bad_clip_r;
    logic [15:0]             mode_rd;
    logic [31:0]             rdata_nxt;
    logic [`MIMC_NUM_CLIENTS-1:0] rand_sel;

    // Masked merge: only bits with mask set and implemented may change
    function automatic logic [15:0] mimc_merge(input logic [15:0] old_v,
                                               input logic [31:0] wr_v,
                                               input logic [15:0] impl_v);
        logic [15:0] en_v;
        en_v = wr_v[31:`MIMC_MASK_LSB] & impl_v;
        return (old_v & ~en_v) | (wr_v[15:0] & en_v);
    endfunction

    // Write strobes per register
    assign mode_wr    = reg_wr_i && (reg_addr_i == `MIMC_MODE_OFS);
    assign scratch_wr = reg_wr_i && (reg_addr_i == `MIMC_SCRATCH_OFS);
    assign rdret_wr   = reg_wr_i && (reg_addr_i == `MIMC_RDRET_OFS);

    // Mode register write
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            mode_r <= `MIMC_MODE_RST;
        end else if (mode_wr) begin
            mode_r <= mimc_merge(mode_r, reg_wdata_i, `MIMC_MODE_WMASK);
        end
    end

    // Scratch pad write
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            scratch_r <= `MIMC_SCRATCH_RST;
        end else if (scratch_wr) begin
            scratch_r <= mimc_merge(scratch_r, reg_wdata_i, `MIMC_SCRATCH_WMASK);
        end
    end

    // Read-return select write
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rdret_r <= `MIMC_RDRET_RST;
        end else if (rdret_wr) begin
            rdret_r <= mimc_merge(rdret_r, reg_wdata_i, `MIMC_RDRET_WMASK);
        end
    end

    // Live idle status of parser and arbiter
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            idle_r <= 1'b0;
        end else begin
            idle_r <= parser_idle_i & arb_idle_i;
        end
    end

    // Read mux; mask halves and reserved bits return zero
    always_comb begin
        mode_rd = mode_r;
        mode_rd[`MIMC_MODE_RINGS_IDLE] = idle_r;
        case (reg_addr_i)
            `MIMC_MODE_OFS:    rdata_nxt = {16'h0000, mode_rd};
            `MIMC_SCRATCH_OFS: rdata_nxt = {16'h0000, scratch_r};
            `MIMC_RDRET_OFS:   rdata_nxt = {16'h0000, rdret_r};
            default:           rdata_nxt = 32'h0000_0000;
        endcase
    end

    // Read answer pulse one cycle after the strobe
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            reg_rvld_o <= 1'b0;
        end else begin
            reg_rvld_o <= reg_rd_i;
        end
    end

    // Read data, zero when no read is answered
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            reg_rdata_o <= 32'h0000_0000;
        end else begin
            reg_rdata_o <= reg_rd_i ? rdata_nxt : 32'h0000_0000;
        end
    end

    // On-chip random data generator
    always_comb begin
        lfsr_nxt = {1'b0, lfsr_r[31:1]};
        if (lfsr_r[0]) begin
            lfsr_nxt = lfsr_nxt ^ `MIMC_LFSR_TAPS;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            lfsr_r <= `MIMC_LFSR_SEED;
        end else begin
            lfsr_r <= lfsr_nxt;
        end
    end

    // Per-client select, effective only with loopback enabled
    assign rand_sel[2:0] = rdret_r[2:0] & {3{rdret_r[`MIMC_RDRET_LOOPBACK]}};
    assign rand_sel[3]   = rdret_r[`MIMC_RDRET_CURSOR]
                           & rdret_r[`MIMC_RDRET_LOOPBACK];
    assign rand_sel[4]   = rdret_r[`MIMC_RDRET_SPRITE_A]
                           & rdret_r[`MIMC_RDRET_LOOPBACK];

    // Read return mux, one stage per client
    genvar gi;
    generate
        for (gi = 0; gi < `MIMC_NUM_CLIENTS; gi = gi + 1) begin : g_cli
            always_ff @(posedge clk_i or negedge arst_n_i) begin
                if (!arst_n_i) begin
                    cli_rdata_o[gi] <= '0;
                end else begin
                    cli_rdata_o[gi].vld  <= mem_rdata_i[gi].vld;
                    cli_rdata_o[gi].data <= rand_sel[gi]
                                            ? (lfsr_r ^ 32'(gi))
                                            : mem_rdata_i[gi].data;
                end
            end
        end
    endgenerate

    // Ring stop request toward parser and arbiter
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rings_stop_o <= 1'b0;
        end else begin
            rings_stop_o <= mode_r[`MIMC_MODE_STOP_RINGS];
        end
    end

    // Update pointer invalidate once the head pointer catches up
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            upd_ptr_clr_o <= 1'b0;
        end else begin
            upd_ptr_clr_o <= mode_r[`MIMC_MODE_INV_UPD] & upd_ptr_vld_i
                             & (head_ptr_i == upd_ptr_i);
        end
    end

    // Flush passed straight on while suspend is set
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            flush_go_o <= 1'b0;
        end else begin
            flush_go_o <= flush_req_i & mode_r[`MIMC_MODE_SUSPEND];
        end
    end

    // Held flush flag, sticky until reset; shows the cycle after the request
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            flush_held_o <= 1'b0;
        end else if (flush_req_i && !mode_r[`MIMC_MODE_SUSPEND]) begin
            flush_held_o <= 1'b1;
        end
    end

    // Closing dummy read after each stream flush
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            dummy_rd_o <= 1'b0;
        end else begin
            dummy_rd_o <= flush_done_i & ~mode_r[`MIMC_MODE_DUMMY_DIS];
        end
    end

    // Identity interrupt masking while an acknowledge is pending
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            id_int_mask_o <= 1'b0;
        end else begin
            id_int_mask_o <= int_ack_pend_i & ~mode_r[`MIMC_MODE_IDMASK_DIS];
        end
    end

    // Oversized physical batch refusal
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            batch_refuse_o <= 1'b0;
        end else begin
            batch_refuse_o <= batch_big_i & ~mode_r[`MIMC_MODE_BIG_BATCH];
        end
    end

    // Flip stall placement and restore flavour
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            flip_stall_r   <= 1'b0;
            slow_restore_r <= 1'b0;
        end else begin
            flip_stall_r   <= mode_r[`MIMC_MODE_ASYNC_FLIP];
            slow_restore_r <= mode_r[`MIMC_MODE_FLUSH_PERF];
        end
    end

    // Power-of-two fence hint
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pow2_r <= 1'b0;
        end else begin
            pow2_r <= mode_r[`MIMC_MODE_POW2_FENCE];
        end
    end

    // Vertex shader cache mode, dispatch timer and batch size
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            vs_lra_r   <= 1'b0;
            vs_timer_r <= 1'b0;
            vs_batch_r <= 2'h0;
        end else begin
            vs_lra_r   <= mode_r[`MIMC_MODE_VS_LRA];
            vs_timer_r <= mode_r[`MIMC_MODE_VS_TIMER];
            vs_batch_r <= mode_r[`MIMC_MODE_VS_TIMER]
                          ? 2'h1 : `MIMC_VS_BATCH;
        end
    end

    // Compression watch enable
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            fbc_watch_r <= 1'b0;
        end else begin
            fbc_watch_r <= mode_r[`MIMC_MODE_FBC_MOD];
        end
    end

    // Outstanding pipe control depth
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pc_depth_r <= 4'h0;
        end else begin
            pc_depth_r <= mode_r[`MIMC_MODE_PC_DEPTH]
                          ? `MIMC_PC_DEPTH_SHALLOW
                          : `MIMC_PC_DEPTH_DEEP;
        end
    end

    // Scratch pad fixes for vertex dispatch and the clipper
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            dual_off_r  <= 1'b0;
            clip_mode_r <= 2'h0;
            bad_clip_r  <= 1'b0;
        end else begin
            dual_off_r  <= scratch_r[`MIMC_SCR_DUAL_DIS];
            clip_mode_r <= {scratch_r[`MIMC_SCR_CLIP_SW],
                            scratch_r[`MIMC_SCR_BAD_VTX]};
            bad_clip_r  <= scratch_r[`MIMC_SCR_BAD_VTX];
        end
    end

    // Steering word, wired from the flops above
    assign ctrl_o = '{
        stall_in_streamer: flip_stall_r,
        slow_restore:      slow_restore_r,
        pow2_fences:       pow2_r,
        vs_lra:            vs_lra_r,
        vs_timer_en:       vs_timer_r,
        vs_batch:          vs_batch_r,
        fbc_watch:         fbc_watch_r,
        pc_depth:          pc_depth_r,
        dual_dispatch_off: dual_off_r,
        clip_mode:         clip_mode_r,
        bad_vtx_must_clip: bad_clip_r
    };

endmodule

// ===== mimc_top_tb.sv
// Directed testbench for the mode control bank
`timescale 1ns/10ps
`include "mimc_cfg.svh"
module mimc_top_tb;
    localparam logic [15:0] MD = `MIMC_MODE_OFS;
    localparam logic [15:0] SC = `MIMC_SCRATCH_OFS;
    localparam logic [15:0] RR = `MIMC_RDRET_OFS;
    logic clk_i = 0, arst_n_i = 0, reg_wr_i = 0, reg_rd_i = 0, reg_rvld_o;
    logic [15:0] reg_addr_i = 0;
    logic [31:0] reg_wdata_i = 0, reg_rdata_o, q;
    logic [31:0] ptr = 32'h0000_1240;
    mimc_pkg::mimc_rdata_s [4:0] mem_rdata_i, cli_rdata_o;
    logic pi = 0, ai = 0, uv = 0, fr = 0, fd = 0, ip = 0, bb = 0;
    logic [5:0] so;
    logic br;
    mimc_pkg::mimc_ctrl_s ctrl_o;
    int n_errors = 0, num_checks = 0, k;
    mimc_top dut_u (.clk_i(clk_i), .arst_n_i(arst_n_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
        .reg_rvld_o(reg_rvld_o), .mem_rdata_i(mem_rdata_i), .cli_rdata_o(cli_rdata_o),
        .parser_idle_i(pi), .arb_idle_i(ai), .rings_stop_o(so[5]), .head_ptr_i(ptr),
        .upd_ptr_i(ptr), .upd_ptr_vld_i(uv), .upd_ptr_clr_o(so[0]), .flush_req_i(fr),
        .flush_done_i(fd), .flush_go_o(so[4]), .flush_held_o(so[3]), .dummy_rd_o(so[2]),
        .int_ack_pend_i(ip), .id_int_mask_o(so[1]), .batch_big_i(bb), .batch_refuse_o(br),
        .ctrl_o(ctrl_o));
    // Core clock
    always #5 clk_i = ~clk_i;
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        reg_wr_i = 1;
        reg_addr_i = a;
        reg_wdata_i = d;
        @(posedge clk_i) #1;
        reg_wr_i = 0;
    endtask
    task automatic rc(input logic [15:0] a, input logic [31:0] e);
        reg_rd_i = 1;
        reg_addr_i = a;
        @(posedge clk_i) #1;
        reg_rd_i = 0;
        q = reg_rdata_o;
        chk("read valid", 1, reg_rvld_o);
        if (e !== 32'hFFFF_FFFF) chk($sformatf("reg %h", a), e, q);
    endtask
    // One cycle of flush, ack, batch and pointer events, then the six responses
    task automatic side(input logic [5:0] e);
        {uv, fr, fd, ip, bb} = 5'h1F;
        @(posedge clk_i) #1;
        {uv, fr, fd, ip, bb} = 5'h00;
        chk("side outputs", e, {so[4:1], br, so[0]});
    endtask
    // Client selects, then which clients return generated data
    task automatic cli(input logic [31:0] w, input logic [4:0] rnd);
        wr(RR, w);
        repeat (2) @(posedge clk_i) #1;
        for (int i = 0; i < 5; i++) chk($sformatf("client %0d", i), {rnd[i], 1'b1},
            {cli_rdata_o[i].data !== mem_rdata_i[i].data, cli_rdata_o[i].vld});
    endtask
    initial begin
        for (int i = 0; i < 5; i++) mem_rdata_i[i] = '{1'b1, 32'h5A5A_0000 + i};
        repeat (4) @(posedge clk_i);
        #1 arst_n_i = 1;
        @(posedge clk_i) #1;
        rc(MD, 0);
        rc(SC, 32'h0307);
        rc(RR, 0);
        rc(16'h2000, 0);
        chk("ctrl", 32'h0483, ctrl_o);
        $display("test reset done");
        wr(MD, 32'hFFFF_FFFF);
        wr(16'h2000, 32'hFFFF_FFFF);
        rc(MD, 32'h0000_EDEF);
        chk("ctrl", 32'hFB43, ctrl_o);
        wr(MD, 32'h0001_0000);
        wr(MD, 32'h0000_0001);
        rc(MD, 32'h0000_EDEE);
        wr(SC, 32'hFFFF_5000);
        rc(SC, 32'h0000_5000);
        chk("ctrl", 32'hFB4C, ctrl_o);
        wr(SC, 32'h0200_0200);
        rc(SC, 32'h0000_5200);
        chk("ctrl", 32'hFB4F, ctrl_o);
        $display("test masked writes done");
        chk("stop", 1, so[5]);
        pi = 1;
        repeat (2) @(posedge clk_i) #1;
        rc(MD, 32'h0000_EDEE);
        ai = 1;
        for (k = 0; k < 20 && q[9] !== 1'b1; k++) rc(MD, 32'hFFFF_FFFF);
        if (q[9] !== 1'b1) begin
            n_errors++;
            wrap_up();
        end
        chk("idle", 32'h0000_EFEE, q);
        wr(MD, 32'h0100_0000);
        @(posedge clk_i) #1;
        chk("stop", 0, so[5]);
        $display("test rings done");
        side(6'b100101);
        wr(MD, 32'h800B_0001);
        side(6'b011011);
        wr(MD, 32'h0800_0000);
        side(6'b011010);
        $display("test events done");
        cli(32'h000F_0009, 5'b00000);
        cli(32'h8000_8000, 5'b01001);
        cli(32'h000F_0006, 5'b10110);
        cli(32'h8000_0000, 5'b00000);
        rc(RR, 32'h0000_0006);
        $display("test returns done");
        wrap_up();
    end
endmodule
